// ---- src/qdac_defines.vh ----
// constants for the quad dac serial load control block
`ifndef QDAC_DEFINES_VH
`define QDAC_DEFINES_VH
// variant select: 1 = 16-bit part, 0 = 14-bit part
`define QDAC_VAR_16 1'b1
`define QDAC_DW 16
`define QDAC_FRAME_16 18
`define QDAC_FRAME_14 16
`define QDAC_SR_W 18
`define QDAC_ZERO 16'h0000
`define QDAC_HALF_16 16'h8000
`define QDAC_HALF_14 16'h2000
`define QDAC_SDO_16 19
`define QDAC_SDO_14 17
// one stage more than the longest delay, so the tap index equals the pulse count
`define QDAC_SDO_W 20
// synchroniser reset levels = idle pin levels {link_clk, cs_n, din, strobe_n, preset_n, msb}
`define QDAC_SYNC_RST 6'h17
`define QDAC_NCH 4
`endif

// ---- src/qdac_sync.v ----
// two flip-flop synchroniser for one pin
`timescale 1ns/10ps
module qdac_sync (
  input wire clock,
  input wire rst,
  input wire reset_value,
  input wire pin,
  output reg sync_out
);
  reg meta;
  // reset value is a port here but only ever tied to a constant by the parent
  always @(posedge clock) begin
    if (rst) begin
      meta <= reset_value;
      sync_out <= reset_value;
    end else begin
      meta <= pin;
      sync_out <= meta;
    end
  end
endmodule // qdac_sync

// ---- src/qdac_core.v ----
// serial load, input and dac registers of the quad dac
`timescale 1ns/10ps
`include "qdac_defines.vh"
module qdac_core (
  input wire clock,
  input wire rst,
  input wire link_clk,
  input wire chip_sel_n,
  input wire ser_din,
  input wire dac_load_strobe_n,
  input wire async_preset_n,
  input wire midscale_sel,
  output reg ser_dout,
  output reg [`QDAC_DW-1:0] dac_a,
  output reg [`QDAC_DW-1:0] dac_b,
  output reg [`QDAC_DW-1:0] dac_c,
  output reg [`QDAC_DW-1:0] dac_d,
  output reg [`QDAC_DW-1:0] in_a,
  output reg [`QDAC_DW-1:0] in_b,
  output reg [`QDAC_DW-1:0] in_c,
  output reg [`QDAC_DW-1:0] in_d
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  wire [5:0] pins;
  wire [5:0] pins_s;
  // idle levels after reset avoid a false link clock edge on release
  wire [5:0] sync_rst = `QDAC_SYNC_RST;
  assign pins = {link_clk, chip_sel_n, ser_din, dac_load_strobe_n, async_preset_n,
                 midscale_sel};
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sync
      qdac_sync u_sync (
        .clock(clock),
        .rst(rst),
        .reset_value(sync_rst[g]),
        .pin(pins[g]),
        .sync_out(pins_s[g])
      );
    end
  endgenerate
  wire sclk_s = pins_s[5];
  wire cs_s = pins_s[4];
  wire sdi_s = pins_s[3];
  wire dac_load_strobe_n_s = pins_s[2];
  wire preset_s = pins_s[1];
  wire msb_s = pins_s[0];
  // ************************************************************
  // edge detection and serial register
  // ************************************************************
  reg sclk_d;
  reg cs_d;
  reg por_done;
  reg [`QDAC_SR_W-1:0] shreg;
  reg [`QDAC_SDO_W-1:0] chain;
  wire sclk_rise = sclk_s & ~sclk_d;
  wire cs_rise = cs_s & ~cs_d;
  // sdi is delayed like sclk, so the sampled bit lines up with the edge
  always @(posedge clock) begin
    if (rst) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
      shreg <= {`QDAC_SR_W{1'b0}};
      chain <= {`QDAC_SDO_W{1'b0}};
    end else begin
      sclk_d <= sclk_s;
      cs_d <= cs_s;
      if (!cs_s && sclk_rise) begin
        shreg <= {shreg[`QDAC_SR_W-2:0], sdi_s};
        chain <= {chain[`QDAC_SDO_W-2:0], sdi_s};
      end
    end
  end
  // chain output tap: the 14-bit part taps two stages earlier
  always @(posedge clock) begin
    if (rst) begin
      ser_dout <= 1'b0;
    end else if (`QDAC_VAR_16) begin
      ser_dout <= chain[`QDAC_SDO_16];
    end else begin
      ser_dout <= chain[`QDAC_SDO_14];
    end
  end
  // ************************************************************
  // frame decode
  // ************************************************************
  reg [1:0] addr;
  reg [`QDAC_DW-1:0] word;
  reg [`QDAC_DW-1:0] preset_code;
  always @* begin
    if (`QDAC_VAR_16) begin
      addr = shreg[`QDAC_FRAME_16-1:`QDAC_FRAME_16-2];
      word = shreg[`QDAC_DW-1:0];
      preset_code = msb_s ? `QDAC_HALF_16 : `QDAC_ZERO;
    end else begin
      addr = shreg[`QDAC_FRAME_14-1:`QDAC_FRAME_14-2];
      word = {2'h0, shreg[`QDAC_DW-3:0]};
      preset_code = msb_s ? `QDAC_HALF_14 : `QDAC_ZERO;
    end
  end
  // ************************************************************
  // input and dac registers
  // ************************************************************
  // the power-up reset cannot read the pin asynchronously, so the first cycle
  // after rst release loads the preset code from the msb synchroniser reset level (1), so half scale
  always @(posedge clock) begin
    if (rst) begin
      por_done <= 1'b0;
      in_a <= `QDAC_ZERO;
      in_b <= `QDAC_ZERO;
      in_c <= `QDAC_ZERO;
      in_d <= `QDAC_ZERO;
      dac_a <= `QDAC_ZERO;
      dac_b <= `QDAC_ZERO;
      dac_c <= `QDAC_ZERO;
      dac_d <= `QDAC_ZERO;
    end else if (!por_done || !preset_s) begin
      por_done <= 1'b1;
      in_a <= preset_code;
      in_b <= preset_code;
      in_c <= preset_code;
      in_d <= preset_code;
      dac_a <= preset_code;
      dac_b <= preset_code;
      dac_c <= preset_code;
      dac_d <= preset_code;
    end else begin
      if (cs_rise && !sclk_s) begin
        case (addr)
          2'h0: in_a <= word;
          2'h1: in_b <= word;
          2'h2: in_c <= word;
          2'h3: in_d <= word;
          default: in_a <= in_a;
        endcase
      end
      // transparent while low lags the input register by one cycle;
      // holding otherwise keeps the reset code until a load
      if (!dac_load_strobe_n_s) begin
        dac_a <= in_a;
        dac_b <= in_b;
        dac_c <= in_c;
        dac_d <= in_d;
      end
    end
  end
endmodule // qdac_core

// ---- verif/qdac_sva.sv ----
// assertions on the quad dac core ports
`timescale 1ns/10ps
module qdac_sva (
  input wire clock, rst, link_clk, chip_sel_n, dac_load_strobe_n,
  input wire async_preset_n, midscale_sel, ser_dout,
  input wire [15:0] dac_a, dac_d, in_a, in_b, in_c, in_d
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // pins pass two flops, so each window waits out that lag
  property p_zero; (!async_preset_n && !midscale_sel) [*6] |-> (in_a | dac_d) == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("zero preset");
  property p_half; (!async_preset_n && midscale_sel) [*6] |-> in_c == 16'h8000 && dac_a == 16'h8000; endproperty
  a_half: assert property (p_half) else $error("half preset");
  property p_hold; (dac_load_strobe_n && async_preset_n) [*5] |=> $stable({dac_a, dac_d}); endproperty
  a_hold: assert property (p_hold) else $error("dac hold");
  property p_follow; (!dac_load_strobe_n && async_preset_n) [*5] |-> dac_a == $past(in_a); endproperty
  a_follow: assert property (p_follow) else $error("dac follow");
  property p_keep; (chip_sel_n && async_preset_n) [*8] |=> $stable({in_a, in_b, in_c, in_d}); endproperty
  a_keep: assert property (p_keep) else $error("input kept");
  property p_cs; chip_sel_n [*6] |=> $stable(ser_dout); endproperty
  a_cs: assert property (p_cs) else $error("shift without select");
  property p_clk; (!link_clk) [*6] |=> $stable(ser_dout); endproperty
  a_clk: assert property (p_clk) else $error("shift without edge");
  property p_por; $fell(rst) && midscale_sel |-> ##[1:4] in_b == 16'h8000 && dac_d == 16'h8000; endproperty
  a_por: assert property (p_por) else $error("power up code");
  c_load: cover property ($rose(chip_sel_n));
  c_strobe: cover property ((!dac_load_strobe_n) [*5]);
  c_preset: cover property ((!async_preset_n) [*6]);
endmodule // qdac_sva
bind qdac_core qdac_sva u_qdac_sva (.clock(clock), .rst(rst), .link_clk(link_clk),
  .chip_sel_n(chip_sel_n), .dac_load_strobe_n(dac_load_strobe_n),
  .async_preset_n(async_preset_n), .midscale_sel(midscale_sel), .ser_dout(ser_dout),
  .dac_a(dac_a), .dac_d(dac_d), .in_a(in_a), .in_b(in_b), .in_c(in_c), .in_d(in_d));

// ---- verif/qdac_host.sv ----
// serial master model driving the link
`timescale 1ns/10ps
module qdac_host (
  input wire clock, ser_dout,
  output logic link_clk = 0, chip_sel_n = 1, ser_din = 0
);
  logic [31:0] hist = 0;
  int n = 0;
  // link clock rests low between frames; three bytes, last 18 bits count
  task send(input logic [23:0] w);
    chip_sel_n <= 0;
    for (int i = 23; i >= 0; i--) begin
      ser_din <= w[i];
      hist = {hist[30:0], w[i]};
      n++;
      repeat (4) @(posedge clock);
      link_clk <= 1;
      repeat (4) @(posedge clock);
      link_clk <= 0;
      repeat (4) @(posedge clock);
      if (n > 19) tb_top.check(ser_dout, hist[19]);
    end
    chip_sel_n <= 1;
    ser_din <= ~w[0];
    repeat (8) @(posedge clock);
  endtask
endmodule // qdac_host

// ---- verif/tb_top.sv ----
// self-checking bench for the quad dac core
`timescale 1ns/10ps
module tb_top;
  logic clock = 0, rst = 1, strobe_n = 1, preset_n = 1, ms = 1;
  wire link_clk, chip_sel_n, ser_din, ser_dout;
  wire [15:0] d[4], q[4];
  logic [15:0] ei[4], ed[4];
  int error_cnt = 0, checked = 0, cyc = 0;
  initial forever #20 clock = ~clock;
  qdac_core u_qdac_core (.clock(clock), .rst(rst), .link_clk(link_clk), .chip_sel_n(chip_sel_n),
    .ser_din(ser_din), .dac_load_strobe_n(strobe_n), .async_preset_n(preset_n),
    .midscale_sel(ms), .ser_dout(ser_dout), .dac_a(d[0]), .dac_b(d[1]), .dac_c(d[2]),
    .dac_d(d[3]), .in_a(q[0]), .in_b(q[1]), .in_c(q[2]), .in_d(q[3]));
  qdac_host u_qdac_host (.clock(clock), .ser_dout(ser_dout), .link_clk(link_clk),
    .chip_sel_n(chip_sel_n), .ser_din(ser_din));
  task check(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function logic [15:0] code(input logic m);
    return m ? 16'h8000 : 16'h0000;
  endfunction
  task check_all;
    for (int k = 0; k < 4; k++) begin
      check(q[k], ei[k]);
      check(d[k], ed[k]);
    end
  endtask
  task report_and_stop;
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  initial begin
    logic [23:0] w;
    void'($urandom(36));
    repeat (2) @(posedge clock);
    rst <= 0;
    repeat (8) @(posedge clock);
    ei = '{4{code(1'b1)}};
    ed = ei;
    check_all;
    for (int i = 0; i < 10; i++) begin
      w = $urandom;
      if (i < 4) w[17:16] = i[1:0];
      u_qdac_host.send(w);
      ei[w[17:16]] = w[15:0];
      check_all;
      strobe_n <= i[0];
      repeat (6) @(posedge clock);
      strobe_n <= 1;
      if (!i[0]) ed = ei;
      repeat (6) @(posedge clock);
      check_all;
    end
    for (int m = 0; m < 2; m++) begin
      ms <= m[0];
      preset_n <= 0;
      repeat (10) @(posedge clock);
      preset_n <= 1;
      repeat (6) @(posedge clock);
      ei = '{4{code(m[0])}};
      ed = ei;
      check_all;
    end
    report_and_stop;
  end
endmodule // tb_top
